/* File: rtl/etc_defs.vh */
// constants for the eight-bit timer/event counter pair
`ifndef ETC_DEFS_VH
`define ETC_DEFS_VH

// register index within a channel (address bit 2 picks the channel)
`define ETC_REG_CNT 2'h0
`define ETC_REG_CMP 2'h1
`define ETC_REG_SEL 2'h2
`define ETC_REG_MODE 2'h3

// channel mode control bit positions
`define ETC_CE_BIT 7
`define ETC_PWM_BIT 6
`define ETC_CHAIN_BIT 4
`define ETC_LVS_BIT 3
`define ETC_LVR_BIT 2
`define ETC_INV_BIT 1
`define ETC_OE_BIT 0

// writable bits of the mode registers (chain bit only on the upper channel)
`define ETC_MODE_MASK0 8'hCF
`define ETC_MODE_MASK1 8'hDF

// reset values
`define ETC_CNT_RST 8'h00
`define ETC_CMP_RST 8'h00
`define ETC_SEL_RST 3'h0
`define ETC_MODE_RST 8'h00

// count clock select codes
`define ETC_SEL_EXT_FALL 3'h0
`define ETC_SEL_EXT_RISE 3'h1
`define ETC_SEL_DIV1 3'h2
`define ETC_SEL_DIV2 3'h3
`define ETC_SEL_DIV4 3'h4
`define ETC_SEL_DIV64 3'h5
`define ETC_SEL_DIV256 3'h6
`define ETC_SEL_OTHER 3'h7

`endif

/* File: rtl/etc_clk_select.v */
// count clock selector: prescaler, external edge detect and source mux
`timescale 1ns/100ps
`default_nettype none
`include "etc_defs.vh"

module etc_clk_select
(
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // sources
  input wire ext_in,
  input wire other_match,
  // selection
  input wire [2:0] sel,
  // one-cycle count tick
  output reg tick
);

  reg [7:0] presc_reg;
  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;
  wire ext_rise;
  wire ext_fall;

  // free-running prescaler and pin synchroniser
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      presc_reg <= 8'h00;
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      presc_reg <= presc_reg + 8'h01;
      sync1_reg <= ext_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // edges seen only after the second synchroniser stage
  assign ext_rise = sync2_reg & ~sync3_reg;
  assign ext_fall = ~sync2_reg & sync3_reg;

  always @*
  begin
    case (sel)
      `ETC_SEL_EXT_FALL: tick = ext_fall;
      `ETC_SEL_EXT_RISE: tick = ext_rise;
      `ETC_SEL_DIV1: tick = 1'b1;
      `ETC_SEL_DIV2: tick = presc_reg[0];
      `ETC_SEL_DIV4: tick = &presc_reg[1:0];
      `ETC_SEL_DIV64: tick = &presc_reg[5:0];
      `ETC_SEL_DIV256: tick = &presc_reg;
      `ETC_SEL_OTHER: tick = other_match;
      default: tick = 1'b0;
    endcase
  end

endmodule
`default_nettype wire

/* File: rtl/etc_timer_pair.v */
// two 8-bit timer/event counter channels with optional 16-bit chaining
`timescale 1ns/100ps
`default_nettype none
`include "etc_defs.vh"

module etc_timer_pair
(
  // clock and reset
  input wire core_clk,
  input wire rstn,
  // register port
  input wire [2:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // count sources
  input wire [1:0] external_count_input,
  input wire other_timer_match_source,
  // timer outputs
  output reg [1:0] timer_output_pin,
  output reg [1:0] match_interrupt
);

  // address decode shared by write and generate logic
  function reg_hit;
    input [2:0] addr;
    input ch;
    input [1:0] r;
    begin
      reg_hit = (addr == {ch, r});
    end
  endfunction

  reg [15:0] cnt_reg;
  reg [15:0] cmp_reg;
  reg [5:0] clk_sel_reg;
  reg [15:0] mode_reg;
  reg [1:0] ff_reg;
  wire [15:0] cnt_next;
  wire [1:0] ff_next;
  wire [1:0] pin_next;
  wire [1:0] irq_next;
  wire [1:0] tick_raw;
  wire chain;
  wire match16;
  wire low_carry;
  integer k;

  // chain bit lives in the upper mode register
  assign chain = mode_reg[8 + `ETC_CHAIN_BIT];
  assign match16 = (cnt_reg == cmp_reg);
  assign low_carry = (cnt_reg[7:0] == 8'hFF);

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : ch
      localparam [0:0] CH = i;
      wire [7:0] cnt;
      wire [7:0] cmp;
      wire [7:0] mode;
      wire casc;
      wire run;
      wire tick;
      wire pwm;
      wire eq;
      wire step;
      wire evt;
      wire ovf;
      wire pwm_off;
      wire mwr;

      assign cnt = cnt_reg[8*i +: 8];
      assign cmp = cmp_reg[8*i +: 8];
      assign mode = mode_reg[8*i +: 8];
      assign casc = chain & CH;
      // upper half follows the lower count enable when chained
      assign run = casc ? mode_reg[`ETC_CE_BIT] : mode[`ETC_CE_BIT];
      // upper half ticks on the lower channel tick when chained
      assign tick = casc ? tick_raw[0] : tick_raw[i];
      assign pwm = mode[`ETC_PWM_BIT] & ~chain;
      assign eq = chain ? match16 : (cnt == cmp);
      assign step = run & tick;
      // match event outside pwm, lower channel only when chained
      assign evt = step & eq & ~pwm & ~casc;
      assign ovf = step & pwm & (cnt == 8'hFF);
      assign pwm_off = step & pwm & (cnt == cmp);
      assign mwr = reg_wr & reg_hit(reg_addr, CH, `ETC_REG_MODE);

      // clear, hold, restart or free-run step
      assign cnt_next[8*i +: 8] = !run ? `ETC_CNT_RST :
                                  !step ? cnt :
                                  (~pwm & eq) ? `ETC_CNT_RST :
                                  casc ? cnt + {7'h00, low_carry} :
                                  cnt + 8'h01;

      // square wave and pwm share the output flip-flop
      // output flip-flop: software set/reset, pwm edges, toggle
      assign ff_next[i] = (mwr & reg_wdata[`ETC_LVS_BIT] & ~reg_wdata[`ETC_LVR_BIT]) ? 1'b1 :
                          (mwr & reg_wdata[`ETC_LVR_BIT] & ~reg_wdata[`ETC_LVS_BIT]) ? 1'b0 :
                          pwm_off ? 1'b0 :
                          ovf ? 1'b1 :
                          (evt & mode[`ETC_INV_BIT]) ? ~ff_reg[i] :
                          ff_reg[i];

      // pin low when disabled; in pwm the inversion bit picks low-active
      assign pin_next[i] = mode[`ETC_OE_BIT] &
                           (pwm ? (ff_reg[i] ^ mode[`ETC_INV_BIT]) : ff_reg[i]);
      assign irq_next[i] = evt;

      etc_clk_select u_sel
      (
        .core_clk(core_clk),
        .rstn(rstn),
        .ext_in(external_count_input[i]),
        .other_match(other_timer_match_source),
        .sel(clk_sel_reg[3*i +: 3]),
        .tick(tick_raw[i])
      );
    end
  endgenerate

  // register writes and channel state
  always @(posedge core_clk)
  begin
    if (!rstn)
    begin
      cnt_reg <= {`ETC_CNT_RST, `ETC_CNT_RST};
      cmp_reg <= {`ETC_CMP_RST, `ETC_CMP_RST};
      clk_sel_reg <= {`ETC_SEL_RST, `ETC_SEL_RST};
      mode_reg <= {`ETC_MODE_RST, `ETC_MODE_RST};
      ff_reg <= 2'h0;
      timer_output_pin <= 2'h0;
      match_interrupt <= 2'h0;
    end
    else
    begin
      // counter advances from logic only, never by a write
      cnt_reg <= cnt_next;
      ff_reg <= ff_next;
      timer_output_pin <= pin_next;
      match_interrupt <= irq_next;
      for (k = 0; k < 2; k = k + 1)
      begin
        if (reg_wr && reg_hit(reg_addr, k[0], `ETC_REG_CMP))
          cmp_reg[8*k +: 8] <= reg_wdata;
        // only the low three select bits are stored
        if (reg_wr && reg_hit(reg_addr, k[0], `ETC_REG_SEL))
          clk_sel_reg[3*k +: 3] <= reg_wdata[2:0];
      end
      if (reg_wr && reg_hit(reg_addr, 1'b0, `ETC_REG_MODE))
        mode_reg[7:0] <= reg_wdata & `ETC_MODE_MASK0;
      if (reg_wr && reg_hit(reg_addr, 1'b1, `ETC_REG_MODE))
        mode_reg[15:8] <= reg_wdata & `ETC_MODE_MASK1;
    end
  end

  // read data registered one cycle after the read strobe
  always @(posedge core_clk)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr[1:0])
        `ETC_REG_CNT: reg_rdata <= cnt_reg[{reg_addr[2], 3'b000} +: 8];
        `ETC_REG_CMP: reg_rdata <= cmp_reg[{reg_addr[2], 3'b000} +: 8];
        `ETC_REG_SEL: reg_rdata <= {5'h00, (reg_addr[2] ? clk_sel_reg[5:3] : clk_sel_reg[2:0])};
        `ETC_REG_MODE: reg_rdata <= reg_addr[2] ? mode_reg[15:8] : mode_reg[7:0];
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: tb/etc_chk_asserts.sv */
// assertions on the timer pair ports
`timescale 1ns/100ps
`default_nettype none
module etc_chk
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register port and outputs
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] timer_output_pin,
  input wire logic [1:0] match_interrupt
);
  logic [7:0] m0_reg;
  logic ch_reg;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // shadow of lower mode and chain bit
  always_ff @(posedge core_clk)
    if (!rstn)
      {m0_reg, ch_reg} <= 9'h000;
    else if (reg_wr && reg_addr == 3'h3)
      m0_reg <= reg_wdata;
    else if (reg_wr && reg_addr == 3'h7)
      ch_reg <= reg_wdata[4];
  a_sel_zero:
    assert property (reg_rd && reg_addr[1:0] == 2'h2 |=> reg_rdata[7:3] == 5'h00)
    else $error("select high bits set");
  a_cmp_readback:
    assert property ((reg_wr && reg_addr == 3'h1) ##1 (reg_rd && reg_addr == 3'h1)
      |=> reg_rdata == $past(reg_wdata, 2)) else $error("compare readback");
  a_cnt_ro:
    assert property ((!m0_reg[7] && reg_wr && reg_addr == 3'h0) ##1
      (reg_rd && reg_addr == 3'h0) |=> reg_rdata == 8'h00) else $error("counter written");
  a_stop_clears:
    assert property ((reg_wr && reg_addr == 3'h3 && !reg_wdata[7]) ##2
      (reg_rd && reg_addr == 3'h0) |=> reg_rdata == 8'h00) else $error("stop not cleared");
  a_chain_clears:
    assert property ((ch_reg && reg_wr && reg_addr == 3'h3 && !reg_wdata[7]) ##2
      (reg_rd && reg_addr == 3'h4) |=> reg_rdata == 8'h00) else $error("upper not cleared");
  a_pwm_quiet:
    assert property (!ch_reg && m0_reg[6] && $past(m0_reg[6], 2) |-> !match_interrupt[0])
    else $error("pwm interrupt");
  a_upper_quiet:
    assert property (ch_reg && $past(ch_reg, 2) |-> !match_interrupt[1])
    else $error("upper interrupt in chain");
  a_sq_toggle:
    assert property (m0_reg[1:0] == 2'h3 && !m0_reg[6] && match_interrupt[0]
      |=> timer_output_pin[0] != $past(timer_output_pin[0])) else $error("no toggle");
  // main scenarios reached
  cover property (match_interrupt[0] && m0_reg[1:0] == 2'h3);
  cover property (ch_reg && match_interrupt[0]);
  cover property (m0_reg[6] && $rose(timer_output_pin[0]));
endmodule
bind etc_timer_pair etc_chk u_chk (.core_clk(core_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .timer_output_pin(timer_output_pin),
  .match_interrupt(match_interrupt));
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the timer pair
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [1:0] external_count_input = 2'h0;
  logic other_timer_match_source = 1'b0;
  wire [7:0] reg_rdata;
  wire [1:0] timer_output_pin;
  wire [1:0] match_interrupt;
  wire [3:0] obs = {timer_output_pin, match_interrupt};
  logic [15:0] d;
  int n_errors = 0;
  int num_checks = 0;
  int gen = 0;
  int k, n, i;
  int dv[8] = '{10, 10, 1, 2, 4, 64, 256, 10};
  etc_timer_pair u_etc_timer_pair (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .external_count_input(external_count_input),
    .other_timer_match_source(other_timer_match_source),
    .timer_output_pin(timer_output_pin), .match_interrupt(match_interrupt));
  // 8 ns clock
  always #4 core_clk = ~core_clk;
  // edges and other-timer pulses, one of each per ten cycles
  always @(negedge core_clk)
  begin
    gen <= (gen == 9) ? 0 : gen + 1;
    external_count_input <= {2{gen < 5}};
    other_timer_match_source <= (gen == 0);
  end
  // expected interval of n+1 events of period p
  function logic [15:0] per_exp(input int n, input int p);
    return 16'((n + 1) * p);
  endfunction
  task stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // register cycles, started and ended at a falling edge
  task wr(input logic [2:0] a, input logic [7:0] v);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'h2, a, v};
    @(negedge core_clk);
  endtask
  task rd(input logic [2:0] a);
    {reg_wr, reg_rd, reg_addr} = {2'h1, a};
    @(negedge core_clk);
    d = {8'h00, reg_rdata};
  endtask
  // bounded wait for a level on obs[s], cycles waited in k
  task wt(input logic [1:0] s, input logic lv);
    {reg_wr, reg_rd} = 2'h0;
    k = 0;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (obs[s] !== lv && k < 3000);
    if (k >= 3000)
    begin
      n_errors++;
      stop_test;
    end
  endtask
  // reset, then the scenario sequence
  initial
  begin
    void'($urandom(75596));
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    @(negedge core_clk);
    for (i = 0; i < 8; i++)
    begin
      rd(i[2:0]);
      chk(d, 16'h0000);
    end
    for (i = 0; i < 8; i++)
    begin
      n = (i == 2) ? 0 : (i == 3) ? 255 : $urandom % 256;
      wr({i[0], 2'h0}, n[7:0]);
      rd({i[0], 2'h0});
      chk(d, 16'h0000);
      wr({i[0], 2'h1}, n[7:0]);
      rd({i[0], 2'h1});
      chk(d, n[15:0]);
      wr({i[0], 2'h2}, ~n[7:0]);
      rd({i[0], 2'h2});
      chk(d, {13'h0000, ~n[2:0]});
    end
    $display("registers done");
    for (i = 0; i < 8; i++)
    begin
      n = $urandom % 4;
      // compare written only while the channel is stopped
      wr({i[0], 2'h1}, n[7:0]);
      wr({i[0], 2'h2}, i[7:0]);
      wr({i[0], 2'h3}, 8'h83);
      wt({1'b0, i[0]}, 1'b1);
      wt({1'b0, i[0]}, 1'b1);
      chk(k[15:0], per_exp(n, dv[i]));
      wr({i[0], 2'h3}, 8'h00);
      rd({i[0], 2'h3});
      rd({i[0], 2'h0});
      chk(d, 16'h0000);
    end
    $display("clock sources done");
    n = $urandom % 8;
    // both compare halves written before the counters start
    wr(3'h7, 8'h10);
    wr(3'h1, n[7:0]);
    wr(3'h5, 8'h01);
    wr(3'h2, 8'h02);
    wr(3'h3, 8'h80);
    wt(2'h0, 1'b1);
    wt(2'h0, 1'b1);
    chk(k[15:0], per_exp(256 + n, 1));
    wr(3'h3, 8'h00);
    // chained count read twice and the two reads compared
    rd(3'h4);
    n = d;
    rd(3'h4);
    chk(d, n[15:0]);
    chk(d, 16'h0000);
    wr(3'h7, 8'h00);
    $display("chain done");
    n = 1 + $urandom % 253;
    // a single compare write, made before pwm starts
    wr(3'h1, n[7:0]);
    wr(3'h3, 8'hC1);
    wt(2'h2, 1'b0);
    wt(2'h2, 1'b1);
    wt(2'h2, 1'b0);
    chk(k[15:0], per_exp(n, 1));
    $display("pwm done");
    stop_test;
  end
endmodule
`default_nettype wire
